// >>> hw/converter_timing_status.sv
// Timing, soft-start timeout and status/telemetry commands of the converter.
// Assumes a command front end delivering one decoded read or write per cycle.
`timescale 1ns/1ns
module converter_timing_status
    import conv_cmd_pkg::*;
#(
    parameter int CYCLES_PER_MS = CYCLES_PER_MS_DEF
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [7:0] i_cmd,
    input wire logic i_wr_en,
    input wire logic [15:0] i_wr_data,
    input wire logic i_rd_en,
    input wire logic i_on,
    input wire logic i_soft_off,
    input wire logic i_vout_ok,
    input wire logic i_clear_faults,
    input wire logic [15:0] i_vout_request,
    input wire logic i_pgood_n,
    input wire logic [7:0] i_status_vout,
    input wire logic [7:0] i_output_current_status,
    input wire logic [7:0] i_status_input,
    input wire logic [7:0] i_status_temp,
    input wire logic [7:0] i_status_comm,
    input wire logic [7:0] i_status_maker,
    input wire logic [15:0] i_vout_meas,
    input wire logic [15:0] i_iout_meas,
    input wire logic [15:0] i_temp_meas,
    output logic [15:0] o_rd_data,
    output logic o_rd_valid,
    output logic o_rd_error,
    output logic o_converting,
    output logic o_softstart,
    output logic o_soft_stop,
    output logic o_softstart_fault,
    output logic [15:0] o_fall_time,
    output logic [15:0] o_vout_target
);

    logic [15:0] rw_q [NUM_RW];
    logic [NUM_RW-1:0] wr_hit;
    seq_state_t state;
    seq_state_t next_state;
    logic [15:0] next_rd_data;
    logic rw_read_hit;
    logic [15:0] rw_read_val;
    logic tmr_expired;
    logic [15:0] target_q;

    function automatic logic is_ro_cmd(input logic [7:0] cmd);
        case (cmd)
            CMD_VOUT_MODE, CMD_SUMMARY_BYTE, CMD_SUMMARY_WORD,
            CMD_VOUT_STATUS, CMD_IOUT_STATUS, CMD_INPUT_STATUS,
            CMD_STATUS_TEMP, CMD_STATUS_COMM, CMD_STATUS_MAKER,
            CMD_VOUT_READING, CMD_IOUT_READING, CMD_READ_TEMP,
            CMD_REVISION: is_ro_cmd = 1'b1;
            default: is_ro_cmd = 1'b0;
        endcase
    endfunction

    // Writable command registers
    // read-only writes dropped
    genvar g;
    generate
        for (g = 0; g < NUM_RW; g++) begin : g_rw
            assign wr_hit[g] = i_wr_en && i_cmd == RW_CMD[g];
            always_ff @(posedge i_mclk) begin
                if (!i_rstn)
                    rw_q[g] <= RW_RST[g];
                else if (i_ce && wr_hit[g])
                    rw_q[g] <= i_wr_data & RW_MASK[g];
            end
        end
    endgenerate

    wire [15:0] ton_limit = rw_q[RW_TON_LIMIT];
    wire [15:0] ton_resp = rw_q[RW_TON_RESP];
    wire [15:0] off_delay = rw_q[RW_OFF_DELAY];
    wire [15:0] fall_time = rw_q[RW_FALL];
    wire [15:0] vout_min = rw_q[RW_VOUT_MIN];
    wire [15:0] options = rw_q[RW_OPTIONS];

    wire softstart_detect_disable = options[DETECT_DISABLE_BIT];

    wire resp_ignore = ton_resp[RESP_HI:RESP_LO] == RESP_IGNORE;
    wire resp_latch = ton_resp[RETRY_HI:RETRY_LO] == RETRY_LATCH;

    // Power sequencing
    // timeout while ramping
    wire ss_timeout = state == ST_SS && !i_vout_ok && tmr_expired;
    wire tmr_start = next_state != state;

    wire [15:0] tmr_limit = state == ST_SS ? ton_limit :
                            state == ST_DELAY ? off_delay : fall_time;

    always_comb begin
        next_state = state;
        case (state)
            ST_IDLE: begin
                if (i_on)
                    next_state = ST_SS;
            end
            ST_SS: begin
                if (!i_on)
                    next_state = ST_IDLE;
                else if (i_vout_ok)
                    next_state = ST_RUN;
                else if (ss_timeout && resp_ignore)
                    next_state = ST_RUN;
                else if (ss_timeout && resp_latch)
                    next_state = ST_LATCH;
                else if (ss_timeout)
                    next_state = ST_RETRY;
            end
            ST_RETRY: begin
                next_state = i_on ? ST_SS : ST_IDLE;
            end
            ST_RUN: begin
                if (!i_on)
                    next_state = i_soft_off ? ST_DELAY : ST_IDLE;
            end
            ST_DELAY: begin
                if (tmr_expired)
                    next_state = ST_FALL;
            end
            ST_FALL: begin
                if (tmr_expired)
                    next_state = ST_IDLE;
            end
            ST_LATCH: begin
                // Stays off until the enable is dropped
                if (!i_on)
                    next_state = ST_IDLE;
            end
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            state <= ST_IDLE;
        else if (i_ce)
            state <= next_state;
    end

    ms_timer #(
        .CYC_PER_MS(CYCLES_PER_MS),
        .W(16)
    ) u_timer (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_start(tmr_start),
        .i_limit(tmr_limit),
        .o_expired(tmr_expired)
    );

    vout_clamp u_clamp (
        .i_mclk(i_mclk),
        .i_rstn(i_rstn),
        .i_ce(i_ce),
        .i_request(i_vout_request),
        .i_min(vout_min),
        .i_rst_value(RW_RST[RW_VOUT_MIN]),
        .o_target(target_q)
    );

    // Status assembly, live from the detail inputs
    // timeout shown in output byte
    wire [7:0] vout_status = i_status_vout | (8'(o_softstart_fault) << VOUT_TON_BIT);
    wire is_off = !o_converting;

    wire [7:0] summary_byte = {1'b0, is_off, vout_status[DET_FAULT_BIT],
        i_output_current_status[DET_FAULT_BIT], i_status_input[VIN_UV_BIT], |i_status_temp,
        |i_status_comm, |i_status_maker} & 8'hFF;

    wire [7:0] status_hi = {|vout_status, |i_output_current_status, |i_status_input,
        |i_status_maker, i_pgood_n, 3'h0};
    wire [15:0] summary_word = {status_hi, summary_byte};

    wire [15:0] temp_value = softstart_detect_disable ? i_temp_meas : TEMP_FIXED_VAL;

    always_comb begin
        rw_read_hit = 1'b0;
        rw_read_val = 16'h0000;
        for (int k = 0; k < NUM_RW; k++) begin
            if (i_cmd == RW_CMD[k]) begin
                rw_read_hit = 1'b1;
                rw_read_val = rw_q[k];
            end
        end
    end

    always_comb begin
        case (i_cmd)
            CMD_VOUT_MODE: next_rd_data = {8'h00, VOUT_MODE_VAL};
            CMD_SUMMARY_BYTE: next_rd_data = {8'h00, summary_byte};
            CMD_SUMMARY_WORD: next_rd_data = summary_word;
            CMD_VOUT_STATUS: next_rd_data = {8'h00, vout_status};
            CMD_IOUT_STATUS: next_rd_data = {8'h00, i_output_current_status};
            CMD_INPUT_STATUS: next_rd_data = {8'h00, i_status_input};
            CMD_STATUS_TEMP: next_rd_data = {8'h00, i_status_temp};
            CMD_STATUS_COMM: next_rd_data = {8'h00, i_status_comm};
            CMD_STATUS_MAKER: next_rd_data = {8'h00, i_status_maker};
            CMD_VOUT_READING: next_rd_data = i_vout_meas;
            CMD_IOUT_READING: next_rd_data = i_iout_meas;
            CMD_READ_TEMP: next_rd_data = temp_value;
            CMD_REVISION: next_rd_data = {8'h00, REVISION_VAL};
            default: next_rd_data = rw_read_val;
        endcase
    end

    wire rd_known = rw_read_hit || is_ro_cmd(i_cmd);

    // Read answer, one cycle after the request
    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_rd_data <= 16'h0000;
            o_rd_valid <= 1'b0;
            o_rd_error <= 1'b0;
        end else if (i_ce) begin
            o_rd_valid <= i_rd_en;
            o_rd_error <= i_rd_en && !rd_known;
            if (i_rd_en)
                o_rd_data <= rd_known ? next_rd_data : 16'h0000;
        end
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            o_softstart_fault <= 1'b0;
        else if (i_ce)
            o_softstart_fault <= ss_timeout || (o_softstart_fault && !i_clear_faults);
    end

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            o_converting <= 1'b0;
            o_softstart <= 1'b0;
            o_soft_stop <= 1'b0;
            o_fall_time <= RW_RST[RW_FALL];
            o_vout_target <= RW_RST[RW_VOUT_MIN];
        end else if (i_ce) begin
            o_converting <= next_state inside {ST_SS, ST_RUN, ST_DELAY};
            o_softstart <= next_state == ST_SS;
            o_soft_stop <= next_state == ST_FALL;
            o_fall_time <= fall_time;
            o_vout_target <= target_q;
        end
    end

    // Checks
    default clocking cb @(posedge i_mclk);
    endclocking
    default disable iff (!i_rstn);

    sequence ss_enter;
        state == ST_IDLE && i_on && i_ce ##1 state == ST_SS;
    endsequence

    sequence rd_of(logic [7:0] c);
        i_rd_en && i_ce && i_cmd == c;
    endsequence

    ss_start_a: assert property (ss_enter |-> $past(tmr_start))
        else $error("soft-start entered without timer restart");

    ss_fault_a: assert property (state == ST_SS && i_ce && tmr_expired && !i_vout_ok
        && i_on |=> o_softstart_fault)
        else $error("timeout did not raise fault");

    ss_resp_a: assert property (ss_timeout && i_ce && i_on && !resp_ignore
        && !resp_latch |=> state == ST_RETRY ##1 state == ST_SS)
        else $error("restart response not taken");

    reset_vals_a: assert property ($rose(i_rstn) |-> ton_limit == RW_RST[RW_TON_LIMIT]
        && ton_resp == RW_RST[RW_TON_RESP] && off_delay == RW_RST[RW_OFF_DELAY]
        && fall_time == RW_RST[RW_FALL])
        else $error("timing defaults wrong");

    rev_read_a: assert property (rd_of(CMD_REVISION) |=> o_rd_valid
        && o_rd_data == {8'h00, REVISION_VAL})
        else $error("revision read wrong");

    temp_fixed_a: assert property (rd_of(CMD_READ_TEMP) && !softstart_detect_disable
        |=> o_rd_data == TEMP_FIXED_VAL)
        else $error("temperature not fixed");

    sbyte_read_a: assert property (rd_of(CMD_SUMMARY_BYTE)
        |=> o_rd_data[SB_IOUT_OC] == $past(i_output_current_status[DET_FAULT_BIT])
        && o_rd_data[SB_OFF] == $past(is_off))
        else $error("status byte wrong");

    vout_ton_a: assert property (rd_of(CMD_VOUT_STATUS) && o_softstart_fault
        |=> o_rd_data[VOUT_TON_BIT])
        else $error("timeout bit missing");

    ro_write_a: assert property (i_wr_en && i_ce && is_ro_cmd(i_cmd)
        |=> $stable(ton_limit) && $stable(vout_min) && $stable(options))
        else $error("read-only write changed state");

    vout_read_a: assert property (rd_of(CMD_VOUT_READING)
        |=> o_rd_data == $past(i_vout_meas))
        else $error("voltage reading not live");

endmodule

// >>> hw/conv_cmd_pkg.sv
// Command codes, defaults and field layout of the timing and status commands.
// Assumes a command front end that hands over decoded reads and writes.
package conv_cmd_pkg;

    // Sequencer timing
    localparam int MS_NS = 1000000;
    localparam int CLK_NS = 4;
    localparam int CYCLES_PER_MS_DEF = MS_NS / CLK_NS;

    localparam logic [7:0] CMD_VOUT_MODE = 8'h20;
    localparam logic [7:0] CMD_SUMMARY_BYTE = 8'h78;
    localparam logic [7:0] CMD_SUMMARY_WORD = 8'h79;
    localparam logic [7:0] CMD_VOUT_STATUS = 8'h7A;
    localparam logic [7:0] CMD_IOUT_STATUS = 8'h7B;
    localparam logic [7:0] CMD_INPUT_STATUS = 8'h7C;
    localparam logic [7:0] CMD_STATUS_TEMP = 8'h7D;
    localparam logic [7:0] CMD_STATUS_COMM = 8'h7E;
    localparam logic [7:0] CMD_STATUS_MAKER = 8'h80;
    localparam logic [7:0] CMD_VOUT_READING = 8'h8B;
    localparam logic [7:0] CMD_IOUT_READING = 8'h8C;
    localparam logic [7:0] CMD_READ_TEMP = 8'h8E;
    localparam logic [7:0] CMD_REVISION = 8'h98;

    // Writable commands, their defaults and writable bits
    localparam int NUM_RW = 6;
    localparam int RW_TON_LIMIT = 0;
    localparam int RW_TON_RESP = 1;
    localparam int RW_OFF_DELAY = 2;
    localparam int RW_FALL = 3;
    localparam int RW_VOUT_MIN = 4;
    localparam int RW_OPTIONS = 5;
    localparam logic [7:0] RW_CMD [NUM_RW] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'hA4, 8'hE5};
    localparam logic [15:0] RW_RST [NUM_RW] =
        '{16'h0064, 16'h00BF, 16'h0000, 16'h0000, 16'h0100, 16'h00C7};
    localparam logic [15:0] RW_MASK [NUM_RW] =
        '{16'hFFFF, 16'h00FF, 16'hFFFF, 16'hFFFF, 16'hFFFF, 16'hFFFF};

    localparam logic [7:0] VOUT_MODE_VAL = 8'h17;
    localparam logic [7:0] REVISION_VAL = 8'h12;
    localparam logic [15:0] TEMP_FIXED_VAL = 16'h0019;
    localparam int DETECT_DISABLE_BIT = 3;

    // Fault response fields
    localparam int RESP_HI = 7;
    localparam int RESP_LO = 6;
    localparam int RETRY_HI = 5;
    localparam int RETRY_LO = 3;
    localparam logic [1:0] RESP_IGNORE = 2'h0;
    localparam logic [2:0] RETRY_LATCH = 3'h0;

    // Status bit positions
    localparam int VOUT_TON_BIT = 2;
    localparam int DET_FAULT_BIT = 7;
    localparam int VIN_UV_BIT = 4;
    localparam int SB_OFF = 6;
    localparam int SB_VOUT_OV = 5;
    localparam int SB_IOUT_OC = 4;
    localparam int SB_VIN_UV = 3;
    localparam int SB_TEMP = 2;
    localparam int SB_COMM = 1;
    localparam int SB_OTHER = 0;
    localparam int SW_VOUT = 15;
    localparam int SW_IOUT = 14;
    localparam int SW_INPUT = 13;
    localparam int SW_MAKER = 12;
    localparam int SW_PGOOD = 11;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b000,
        ST_SS = 3'b001,
        ST_RUN = 3'b010,
        ST_RETRY = 3'b011,
        ST_LATCH = 3'b100,
        ST_DELAY = 3'b101,
        ST_FALL = 3'b110
    } seq_state_t;

endpackage

// >>> hw/ms_timer.sv
// Millisecond timer restarted by a pulse, compared against a limit in ms.
// Assumes the caller pulses i_start on entry to each timed phase.
`timescale 1ns/1ns
module ms_timer
    import conv_cmd_pkg::*;
#(
    parameter int CYC_PER_MS = CYCLES_PER_MS_DEF,
    parameter int W = 16
) (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic i_start,
    input wire logic [W-1:0] i_limit,
    output logic o_expired
);
    localparam int CW = $clog2(CYC_PER_MS + 1);
    logic [CW-1:0] cyc;
    logic [W-1:0] ms;
    wire ms_tick = cyc == CW'(CYC_PER_MS - 1);
    wire ms_full = &ms;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn) begin
            cyc <= '0;
            ms <= '0;
        end else if (i_ce) begin
            cyc <= (i_start || ms_tick) ? '0 : cyc + 1'b1;
            // Saturate so a long phase never wraps into a false pass
            if (i_start)
                ms <= '0;
            else if (ms_tick && !ms_full)
                ms <= ms + 1'b1;
        end
    end

    assign o_expired = ms >= i_limit;

    timer_zero_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_start && i_ce |=> ms == '0 && cyc == '0)
        else $error("timer not cleared on start");
endmodule

// >>> hw/vout_clamp.sv
// Output setpoint floor: any requested target below the minimum is raised to it.
// Both values are linear with exponent -9, so a plain compare suffices.
`timescale 1ns/1ns
module vout_clamp (
    input wire logic i_mclk,
    input wire logic i_rstn,
    input wire logic i_ce,
    input wire logic [15:0] i_request,
    input wire logic [15:0] i_min,
    input wire logic [15:0] i_rst_value,
    output logic [15:0] o_target
);
    wire below_min = i_request < i_min;
    wire [15:0] next_target = below_min ? i_min : i_request;

    always_ff @(posedge i_mclk) begin
        if (!i_rstn)
            o_target <= i_rst_value;
        else if (i_ce)
            o_target <= next_target;
    end

    clamp_floor_a: assert property (@(posedge i_mclk) disable iff (!i_rstn)
        i_ce |=> o_target >= $past(i_min) && (o_target == $past(i_request)
            || o_target == $past(i_min)))
        else $error("setpoint below minimum");
endmodule

// >>> testbench/conv_host_model.sv
// Host side of the command port: one read or write per task call.
// Assumes each call starts just after a rising edge of i_mclk.
`timescale 1ns/1ns
module conv_host_model (
    input wire logic i_mclk,
    input wire logic [15:0] i_rd_data,
    input wire logic i_rd_valid,
    input wire logic i_rd_error,
    output logic [7:0] o_cmd,
    output logic o_wr_en,
    output logic [15:0] o_wr_data,
    output logic o_rd_en
);
    initial begin
        o_cmd = 8'h00;
        o_wr_en = 1'b0;
        o_wr_data = 16'h0000;
        o_rd_en = 1'b0;
    end

    task automatic wr(input logic [7:0] cmd, input logic [15:0] data);
        o_cmd <= cmd;
        o_wr_data <= data;
        o_wr_en <= 1'b1;
        @(posedge i_mclk);
        o_wr_en <= 1'b0;
        // Released data must not look like the last word
        o_wr_data <= ~data;
        @(posedge i_mclk);
    endtask

    task automatic rd(input logic [7:0] cmd, output logic [15:0] data, output logic [1:0] flags);
        o_cmd <= cmd;
        o_rd_en <= 1'b1;
        @(posedge i_mclk);
        o_rd_en <= 1'b0;
        // Valid and error flags stand only in the cycle after the request edge; data holds until the next read
        #1;
        data = i_rd_data;
        flags = {i_rd_valid, i_rd_error};
        @(posedge i_mclk);
    endtask
endmodule

// >>> testbench/converter_timing_status_tb.sv
// Self-checking bench for the timing, status and telemetry commands.
// Assumes reads answer one cycle after the request edge.
`timescale 1ns/1ns
module converter_timing_status_tb;
    localparam int CPM = 4;
    logic mclk = 1'b0;
    logic rstn = 1'b0, ce = 1'b1, on = 1'b0, soft_off = 1'b0, vout_ok = 1'b0, clr = 1'b0;
    logic pgood_n = 1'b1;
    logic [7:0] sv = 8'h00, si = 8'h00, sn = 8'h00, st = 8'h00, sc = 8'h00, sm = 8'h00;
    logic [15:0] vreq = 16'h0000, vm = 16'h0000, im = 16'h0000, tm = 16'h0000;
    logic [7:0] cmd;
    logic [15:0] wr_data, rd_data, fall_time, target;
    logic wr_en, rd_en, rd_valid, rd_error, converting, softstart, soft_stop, fault;
    logic [3:0] flags;
    int n_errors = 0;
    int checked = 0;
    int seed;
    logic [15:0] regs [256];
    logic [7:0] rw_q [$] = '{8'h62, 8'h63, 8'h64, 8'h65, 8'hA4};

    assign flags = {softstart, fault, soft_stop, converting};
    always #2 mclk = ~mclk;

    converter_timing_status #(.CYCLES_PER_MS(CPM)) dut_u (
        .i_mclk(mclk), .i_rstn(rstn), .i_ce(ce), .i_cmd(cmd), .i_wr_en(wr_en),
        .i_wr_data(wr_data), .i_rd_en(rd_en), .i_on(on), .i_soft_off(soft_off),
        .i_vout_ok(vout_ok), .i_clear_faults(clr), .i_vout_request(vreq), .i_pgood_n(pgood_n),
        .i_status_vout(sv), .i_output_current_status(si), .i_status_input(sn), .i_status_temp(st),
        .i_status_comm(sc), .i_status_maker(sm), .i_vout_meas(vm), .i_iout_meas(im),
        .i_temp_meas(tm), .o_rd_data(rd_data), .o_rd_valid(rd_valid), .o_rd_error(rd_error),
        .o_converting(converting), .o_softstart(softstart), .o_soft_stop(soft_stop),
        .o_softstart_fault(fault), .o_fall_time(fall_time), .o_vout_target(target)
    );

    conv_host_model host_u (
        .i_mclk(mclk), .i_rd_data(rd_data), .i_rd_valid(rd_valid), .i_rd_error(rd_error),
        .o_cmd(cmd), .o_wr_en(wr_en), .o_wr_data(wr_data), .o_rd_en(rd_en)
    );

    task automatic check(input logic [15:0] got, input logic [15:0] exp, input logic [7:0] c);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("mismatch at %0t cmd %h got %h expected %h", $time, c, got, exp);
        end
    endtask

    task automatic rd_chk(input logic [7:0] c, input logic [15:0] mask, input logic [15:0] exp,
                          input logic [1:0] fexp);
        logic [15:0] d;
        logic [1:0] f;
        host_u.rd(c, d, f);
        check({14'h0, f}, {14'h0, fexp}, c);
        check(d & mask, exp, c);
    endtask

    task automatic rw_chk(input int i);
        rd_chk(rw_q[i], 16'hFFFF, regs[rw_q[i]], 2'b10);
    endtask

    // Waits until flags[b] reaches lvl; n counts edges; returns on an edge
    task automatic wait_hi(input int b, input logic lvl, output int n);
        n = 0;
        while (flags[b] !== lvl && n < 200) begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (n == 200) check(16'h0000, 16'h0001, 8'h00);
        @(posedge mclk);
    endtask

    task automatic wrap_up;
        $display("checked %0d, mismatches %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("bench passed");
        end else begin
            $display("bench failed");
        end
        $finish;
    endtask

    initial begin
        int n;
        logic [31:0] r;
        logic [15:0] e;
        seed = 56348;
        regs[8'h62] = 16'h0064;
        regs[8'h63] = 16'h00BF;
        regs[8'h64] = 16'h0000;
        regs[8'h65] = 16'h0000;
        regs[8'hA4] = 16'h0100;
        repeat (10) @(posedge mclk);
        rstn <= 1'b1;
        @(posedge mclk);
        foreach (rw_q[i]) rw_chk(i);
        rd_chk(8'h98, 16'hFFFF, 16'h0012, 2'b10);
        rd_chk(8'h20, 16'hFFFF, 16'h0017, 2'b10);
        rd_chk(8'h8E, 16'hFFFF, 16'h0019, 2'b10);
        check(target, 16'h0100, 8'hA4);
        $display("test reset values done");

        foreach (rw_q[i]) begin
            r = $random(seed);
            regs[rw_q[i]] = (rw_q[i] == 8'h63) ? {8'h00, r[7:0]} : r[15:0];
            host_u.wr(rw_q[i], r[15:0]);
        end
        // Frozen clock enable must drop this write
        ce <= 1'b0;
        host_u.wr(8'h64, 16'h5A5A);
        ce <= 1'b1;
        host_u.wr(8'h98, 16'h0033);
        host_u.wr(8'h8E, 16'h1234);
        foreach (rw_q[i]) rw_chk(i);
        rd_chk(8'h98, 16'hFFFF, 16'h0012, 2'b10);
        rd_chk(8'h8E, 16'hFFFF, 16'h0019, 2'b10);
        rd_chk(8'h77, 16'hFFFF, 16'h0000, 2'b11);
        check(fall_time, regs[8'h65], 8'h65);
        $display("test write and read back done");

        repeat (4) begin
            r = $random(seed);
            {sv, si, sn, st} <= r;
            r = $random(seed);
            {sc, sm, vm} <= r;
            r = $random(seed);
            {im, tm} <= r;
            pgood_n <= r[0];
            @(posedge mclk);
            rd_chk(8'h7A, 16'hFFFF, {8'h00, sv}, 2'b10);
            rd_chk(8'h7B, 16'hFFFF, {8'h00, si}, 2'b10);
            rd_chk(8'h7C, 16'hFFFF, {8'h00, sn}, 2'b10);
            rd_chk(8'h7D, 16'hFFFF, {8'h00, st}, 2'b10);
            rd_chk(8'h7E, 16'hFFFF, {8'h00, sc}, 2'b10);
            rd_chk(8'h80, 16'hFFFF, {8'h00, sm}, 2'b10);
            rd_chk(8'h8B, 16'hFFFF, vm, 2'b10);
            rd_chk(8'h8C, 16'hFFFF, im, 2'b10);
            // Converter is off here, so the off bit reads one
            e = {9'h000, 1'b1, sv[7], si[7], sn[4], |st, |sc, |sm};
            rd_chk(8'h78, 16'hFFFF, e, 2'b10);
            e = {|sv, |si, |sn, |sm, pgood_n, 3'h0, e[7:0]};
            rd_chk(8'h79, 16'hFFFF, e, 2'b10);
        end
        $display("test status and telemetry done");

        host_u.wr(8'hE5, 16'h00CF);
        rd_chk(8'h8E, 16'hFFFF, tm, 2'b10);
        host_u.wr(8'hE5, 16'h00C7);
        rd_chk(8'h8E, 16'hFFFF, 16'h0019, 2'b10);
        $display("test temperature option done");

        host_u.wr(8'hA4, 16'h0100);
        repeat (8) begin
            r = $random(seed);
            vreq <= {6'h00, r[9:0]};
            repeat (4) @(posedge mclk);
            e = (vreq < 16'h0100) ? 16'h0100 : vreq;
            check(target, e, 8'hA4);
        end
        $display("test setpoint floor done");

        host_u.wr(8'h62, 16'h0002);
        host_u.wr(8'h63, 16'h00BF);
        sv <= 8'h00;
        on <= 1'b1;
        wait_hi(3, 1'b1, n);
        check(16'(n), 16'h0001, 8'h62);
        wait_hi(2, 1'b1, n);
        check(16'(n >= 7 && n <= 10), 16'h0001, 8'h62);
        wait_hi(3, 1'b1, n);
        check(16'(n <= 3), 16'h0001, 8'h63);
        rd_chk(8'h7A, 16'h0004, 16'h0004, 2'b10);
        clr <= 1'b1;
        @(posedge mclk);
        clr <= 1'b0;
        vout_ok <= 1'b1;
        wait_hi(3, 1'b0, n);
        check({14'h0, fault, converting}, 16'h0001, 8'h62);
        host_u.wr(8'h64, 16'h0001);
        host_u.wr(8'h65, 16'h0003);
        // The output copy lands one edge after the register
        @(posedge mclk);
        check(fall_time, 16'h0003, 8'h65);
        soft_off <= 1'b1;
        on <= 1'b0;
        wait_hi(1, 1'b1, n);
        check(16'(n >= 4 && n <= 7), 16'h0001, 8'h64);
        wait_hi(1, 1'b0, n);
        check(16'(n >= 11 && n <= 14), 16'h0001, 8'h65);
        check({15'h0000, converting}, 16'h0000, 8'h65);
        host_u.wr(8'h63, 16'h0000);
        vout_ok <= 1'b0;
        on <= 1'b1;
        repeat (24) @(posedge mclk);
        check({14'h0, softstart, converting}, 16'h0001, 8'h63);
        // Latch-off response: stays off while the enable stays high
        soft_off <= 1'b0;
        on <= 1'b0;
        clr <= 1'b1;
        host_u.wr(8'h63, 16'h0080);
        clr <= 1'b0;
        on <= 1'b1;
        repeat (24) @(posedge mclk);
        check({13'h0, fault, softstart, converting}, 16'h0004, 8'h63);
        on <= 1'b0;
        $display("test sequencer timing done");
        wrap_up;
    end

    initial begin
        #200000;
        n_errors++;
        wrap_up;
    end
endmodule
